/* File: core/tcrt_timers.v */
// Three 16-bit capture/reload timers, toggle outputs on timers two and four only, with a plain register port
`timescale 1ns/1ps
`include "tcrt_defines.vh"

module tcrt_timers (
    input  wire        sys_clk,
    input  wire        rstn,
    input  wire [4:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    input  wire        ext_osc_clk,
    input  wire        shared_count_pin,
    input  wire        shared_trigger_pin,
    input  wire        count_pin_four,
    input  wire        trigger_pin_four,
    output wire        toggle_pin_two,
    output wire        toggle_pin_two_oe_n,
    output wire        toggle_pin_four,
    output wire        toggle_pin_four_oe_n,
    output wire [2:0]  timer_irq
);
    reg  [1:0]  cnt_sync_a;
    reg  [1:0]  trg_sync_a;
    reg  [1:0]  cnt_sync_b;
    reg  [1:0]  trg_sync_b;
    reg  [1:0]  osc_sync;
    reg         cnt_prev_a;
    reg         trg_prev_a;
    reg         cnt_prev_b;
    reg         trg_prev_b;
    reg         osc_prev;
    reg         div2_reg;
    reg  [3:0]  div12_reg;
    reg  [2:0]  ext8_reg;
    wire        osc_rise;
    wire        en_div2;
    wire        en_div12;
    wire        en_ext8;
    wire        fall_cnt_a;
    wire        fall_trg_a;
    wire        fall_cnt_b;
    wire        fall_trg_b;
    wire [7:0]  rd_two;
    wire [7:0]  rd_three;
    wire [7:0]  rd_four;
    wire        wr_two;
    wire        wr_three;
    wire        wr_four;

    // Two-stage synchronisers; only the second stage feeds edge logic
    always @(posedge sys_clk) begin
        if (!rstn) begin
            cnt_sync_a <= 2'b11;
            trg_sync_a <= 2'b11;
            cnt_sync_b <= 2'b11;
            trg_sync_b <= 2'b11;
            osc_sync   <= 2'b00;
            cnt_prev_a <= 1'b1;
            trg_prev_a <= 1'b1;
            cnt_prev_b <= 1'b1;
            trg_prev_b <= 1'b1;
            osc_prev   <= 1'b0;
        end else begin
            cnt_sync_a <= {cnt_sync_a[0], shared_count_pin};
            trg_sync_a <= {trg_sync_a[0], shared_trigger_pin};
            cnt_sync_b <= {cnt_sync_b[0], count_pin_four};
            trg_sync_b <= {trg_sync_b[0], trigger_pin_four};
            osc_sync   <= {osc_sync[0], ext_osc_clk};
            cnt_prev_a <= cnt_sync_a[1];
            trg_prev_a <= trg_sync_a[1];
            cnt_prev_b <= cnt_sync_b[1];
            trg_prev_b <= trg_sync_b[1];
            osc_prev   <= osc_sync[1];
        end
    end

    assign fall_cnt_a = cnt_prev_a & ~cnt_sync_a[1];
    assign fall_trg_a = trg_prev_a & ~trg_sync_a[1];
    assign fall_cnt_b = cnt_prev_b & ~cnt_sync_b[1];
    assign fall_trg_b = trg_prev_b & ~trg_sync_b[1];
    assign osc_rise   = osc_sync[1] & ~osc_prev;

    // Clock-enable dividers shared by all three timers
    always @(posedge sys_clk) begin
        if (!rstn) begin
            div2_reg  <= 1'b0;
            div12_reg <= 4'h0;
            ext8_reg  <= 3'h0;
        end else begin
            div2_reg  <= ~div2_reg;
            div12_reg <= (div12_reg == `TCRT_DIV12_LAST) ? 4'h0 : div12_reg + 4'h1;
            if (osc_rise) begin
                ext8_reg <= ext8_reg + 3'h1;
            end
        end
    end

    assign en_div2  = div2_reg;
    assign en_div12 = (div12_reg == `TCRT_DIV12_LAST);
    assign en_ext8  = osc_rise & (ext8_reg == `TCRT_EXT8_LAST);

    assign wr_two   = reg_wr & (reg_addr[4:3] == `TCRT_BANK_TWO);
    assign wr_three = reg_wr & (reg_addr[4:3] == `TCRT_BANK_THREE);
    assign wr_four  = reg_wr & (reg_addr[4:3] == `TCRT_BANK_FOUR);

    // Timers two and three both watch the shared pins
    tcrt_channel #(.HAS_TOGGLE(1)) u_two (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .en_div1    (1'b1),
        .en_div2    (en_div2),
        .en_div12   (en_div12),
        .en_ext8    (en_ext8),
        .pin_fall   (fall_cnt_a),
        .trig_fall  (fall_trg_a),
        .trig_level (trg_sync_a[1]),
        .wr_en      (wr_two),
        .wr_ofs     (reg_addr[2:0]),
        .wr_data    (reg_wdata),
        .rd_ofs     (reg_addr[2:0]),
        .rd_val     (rd_two),
        .toggle_out (toggle_pin_two),
        .toggle_oe  (toggle_pin_two_oe_n),
        .irq_req    (timer_irq[0])
    );

    tcrt_channel #(.HAS_TOGGLE(0)) u_three (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .en_div1    (1'b1),
        .en_div2    (en_div2),
        .en_div12   (en_div12),
        .en_ext8    (en_ext8),
        .pin_fall   (fall_cnt_a),
        .trig_fall  (fall_trg_a),
        .trig_level (trg_sync_a[1]),
        .wr_en      (wr_three),
        .wr_ofs     (reg_addr[2:0]),
        .wr_data    (reg_wdata),
        .rd_ofs     (reg_addr[2:0]),
        .rd_val     (rd_three),
        .toggle_out (),
        .toggle_oe  (),
        .irq_req    (timer_irq[1])
    );

    tcrt_channel #(.HAS_TOGGLE(1)) u_four (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .en_div1    (1'b1),
        .en_div2    (en_div2),
        .en_div12   (en_div12),
        .en_ext8    (en_ext8),
        .pin_fall   (fall_cnt_b),
        .trig_fall  (fall_trg_b),
        .trig_level (trg_sync_b[1]),
        .wr_en      (wr_four),
        .wr_ofs     (reg_addr[2:0]),
        .wr_data    (reg_wdata),
        .rd_ofs     (reg_addr[2:0]),
        .rd_val     (rd_four),
        .toggle_out (toggle_pin_four),
        .toggle_oe  (toggle_pin_four_oe_n),
        .irq_req    (timer_irq[2])
    );

    // Read data registered one cycle after the strobe; unmapped reads give zero
    always @(posedge sys_clk) begin
        if (!rstn) begin
            reg_rdata <= `TCRT_RST_BYTE;
        end else if (reg_rd) begin
            case (reg_addr[4:3])
                `TCRT_BANK_TWO:   reg_rdata <= rd_two;
                `TCRT_BANK_THREE: reg_rdata <= rd_three;
                `TCRT_BANK_FOUR:  reg_rdata <= rd_four;
                default:          reg_rdata <= `TCRT_RST_BYTE;
            endcase
        end else begin
            reg_rdata <= `TCRT_RST_BYTE;
        end
    end
endmodule // tcrt_timers

// One timer channel: count, capture/reload, flags, toggle output
module tcrt_channel #(
    parameter HAS_TOGGLE = 1
) (
    input  wire        sys_clk,
    input  wire        rstn,
    input  wire        en_div1,
    input  wire        en_div2,
    input  wire        en_div12,
    input  wire        en_ext8,
    input  wire        pin_fall,
    input  wire        trig_fall,
    input  wire        trig_level,
    input  wire        wr_en,
    input  wire [2:0]  wr_ofs,
    input  wire [7:0]  wr_data,
    input  wire [2:0]  rd_ofs,
    output reg  [7:0]  rd_val,
    output wire        toggle_out,
    output wire        toggle_oe,
    output wire        irq_req
);
    reg  [7:0]  control_reg;
    reg  [4:0]  config_reg;
    reg  [15:0] cap_reg;
    reg  [15:0] count_reg;
    reg         toggle_reg;
    reg         tick;
    reg         go_down;
    reg         trig_act;
    reg  [15:0] count_next;
    reg  [15:0] cap_next;
    reg         ovf_evt;
    reg         exf_evt;
    reg         exf_flip;

    // Control and configuration fields used by the count logic
    wire        run    = control_reg[`TCRT_CTL_RUN];
    wire        capsel = control_reg[`TCRT_CTL_CAPSEL];
    wire        exen   = control_reg[`TCRT_CTL_EXEN];
    wire        dcen   = config_reg[`TCRT_CFG_DCEN];
    wire [1:0]  src    = config_reg[`TCRT_CFG_SRC_HI:`TCRT_CFG_SRC_LO];

    // Tick select: pin edges in counter function, else the chosen divider
    always @* begin
        if (control_reg[`TCRT_CTL_CNTSEL]) begin
            tick = pin_fall;
        end else begin
            case (src)
                `TCRT_SRC_DIV12: tick = en_div12;
                `TCRT_SRC_DIV1:  tick = en_div1;
                `TCRT_SRC_EXT8:  tick = en_ext8;
                `TCRT_SRC_DIV2:  tick = en_div2;
                default:         tick = 1'b0;
            endcase
        end
    end

    // Next count, capture value and flag events for this cycle
    always @* begin
        go_down    = dcen & ~trig_level;
        trig_act   = exen & ~dcen & trig_fall;
        count_next = count_reg;
        cap_next   = cap_reg;
        ovf_evt    = 1'b0;
        exf_evt    = 1'b0;
        exf_flip   = 1'b0;
        if (run && tick) begin
            if (go_down) begin
                if (capsel) begin
                    count_next = count_reg - 16'h0001;
                    ovf_evt    = (count_reg == `TCRT_RST_WORD);
                end else if (count_reg == cap_reg) begin
                    count_next = `TCRT_ALL_ONES;
                    ovf_evt    = 1'b1;
                end else begin
                    count_next = count_reg - 16'h0001;
                end
            end else if (count_reg == `TCRT_ALL_ONES) begin
                ovf_evt    = 1'b1;
                count_next = capsel ? `TCRT_RST_WORD : cap_reg;
            end else begin
                count_next = count_reg + 16'h0001;
            end
        end
        // A trigger edge in the same cycle as a tick takes the count
        if (trig_act) begin
            exf_evt = 1'b1;
            if (capsel) begin
                cap_next = count_reg;
            end else begin
                count_next = cap_reg;
            end
        end
        // Auto-reload wraps flip the external flag instead of setting it
        if (!capsel && ovf_evt) begin
            exf_flip = 1'b1;
        end
    end

    always @(posedge sys_clk) begin
        if (!rstn) begin
            control_reg <= `TCRT_RST_BYTE;
            config_reg  <= `TCRT_RST_CFG;
            cap_reg     <= `TCRT_RST_WORD;
            count_reg   <= `TCRT_RST_WORD;
            toggle_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            cap_reg   <= cap_next;
            // A software write to a count byte overrides the running count
            if (wr_en) begin
                case (wr_ofs)
                    `TCRT_OFS_CONTROL: control_reg <= {wr_data[7:6], 2'b00, wr_data[3:0]};
                    `TCRT_OFS_CONFIG:  config_reg  <= wr_data[4:0];
                    `TCRT_OFS_CAP_LOW:  cap_reg[7:0]    <= wr_data;
                    `TCRT_OFS_CAP_HIGH: cap_reg[15:8]   <= wr_data;
                    `TCRT_OFS_CNT_LOW:  count_reg[7:0]  <= wr_data;
                    `TCRT_OFS_CNT_HIGH: count_reg[15:8] <= wr_data;
                    default: ;
                endcase
            end
            // Hardware sets win over a software write in the same cycle
            if (ovf_evt) begin
                control_reg[`TCRT_CTL_OVF] <= 1'b1;
            end
            if (exf_flip) begin
                control_reg[`TCRT_CTL_EXF] <= ~control_reg[`TCRT_CTL_EXF];
            end else if (exf_evt) begin
                control_reg[`TCRT_CTL_EXF] <= 1'b1;
            end
            // A wrap in the same cycle as a toggle-state write wins
            if (HAS_TOGGLE != 0) begin
                if (ovf_evt && !capsel) begin
                    toggle_reg <= ~toggle_reg;
                end else if (wr_en && wr_ofs == `TCRT_OFS_CONFIG) begin
                    toggle_reg <= wr_data[`TCRT_CFG_TOG];
                end
            end
        end
    end

    assign toggle_out = (HAS_TOGGLE != 0) ? toggle_reg : 1'b0;
    // Pin enable is active low and follows the output-enable bit
    assign toggle_oe  = ~((HAS_TOGGLE != 0) & config_reg[`TCRT_CFG_TOE]);
    // Flags in auto-reload mode: external flag toggling does not interrupt
    assign irq_req    = control_reg[`TCRT_CTL_OVF] |
                        (capsel & control_reg[`TCRT_CTL_EXF]);

    // Read mux of this channel; spare offsets read zero
    always @* begin
        case (rd_ofs)
            `TCRT_OFS_CONTROL:  rd_val = control_reg;
            `TCRT_OFS_CONFIG:   rd_val = {3'b000, config_reg[4:3],
                                          toggle_out, config_reg[1:0]};
            `TCRT_OFS_CAP_LOW:  rd_val = cap_reg[7:0];
            `TCRT_OFS_CAP_HIGH: rd_val = cap_reg[15:8];
            `TCRT_OFS_CNT_LOW:  rd_val = count_reg[7:0];
            `TCRT_OFS_CNT_HIGH: rd_val = count_reg[15:8];
            default:            rd_val = `TCRT_RST_BYTE;
        endcase
    end
endmodule // tcrt_channel

/* File: core/tcrt_defines.vh */
// Register addresses, field positions, reset values and clock-divider counts of the timer block
`ifndef TCRT_DEFINES_VH
`define TCRT_DEFINES_VH

// Register index within one timer bank (addr[2:0]); bank select is addr[4:3]
`define TCRT_OFS_CONTROL    3'h0
`define TCRT_OFS_CONFIG     3'h1
`define TCRT_OFS_CAP_LOW    3'h2
`define TCRT_OFS_CAP_HIGH   3'h3
`define TCRT_OFS_CNT_LOW    3'h4
`define TCRT_OFS_CNT_HIGH   3'h5

// Bank select values
`define TCRT_BANK_TWO       2'h0
`define TCRT_BANK_THREE     2'h1
`define TCRT_BANK_FOUR      2'h2

// Control register fields
`define TCRT_CTL_OVF        7
`define TCRT_CTL_EXF        6
`define TCRT_CTL_EXEN       3
`define TCRT_CTL_RUN        2
`define TCRT_CTL_CNTSEL     1
`define TCRT_CTL_CAPSEL     0

// Configuration register fields
`define TCRT_CFG_SRC_HI     4
`define TCRT_CFG_SRC_LO     3
`define TCRT_CFG_TOG        2
`define TCRT_CFG_TOE        1
`define TCRT_CFG_DCEN       0

// Clock source encodings
`define TCRT_SRC_DIV12      2'h0
`define TCRT_SRC_DIV1       2'h1
`define TCRT_SRC_EXT8       2'h2
`define TCRT_SRC_DIV2       2'h3

// Reset values and the all-ones wrap count
`define TCRT_RST_BYTE       8'h00
`define TCRT_RST_CFG        5'h00
`define TCRT_RST_WORD       16'h0000
`define TCRT_ALL_ONES       16'hFFFF

// Divider terminal counts
`define TCRT_DIV12_LAST     4'hB
`define TCRT_EXT8_LAST      3'h7

`endif

/* File: test/tcrt_pin_model.sv */
// Far-side pin model: count pins, trigger pins and a free-running oscillator
`timescale 1ns/1ps
module tcrt_pin_model (
    input  logic       sys_clk,
    output logic       ext_osc_clk,
    output logic [1:0] cnt_pin,
    output logic [1:0] trg_pin
);
    initial begin
        ext_osc_clk = 1'b0;
        cnt_pin     = 2'b11;
        trg_pin     = 2'b11;
    end
    // Oscillator runs free and slower than the system clock
    always #97 ext_osc_clk = ~ext_osc_clk;
    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Each level is held long enough for the synchroniser to see it
    task automatic cnt_fall(input int i);
        @(posedge sys_clk);
        cnt_pin[i] <= 1'b0;
        hold(4);
        cnt_pin[i] <= 1'b1;
        hold(4);
    endtask
    // A 1-to-0 change is a trigger edge; the level steers direction
    task automatic trg_set(input int i, input logic v);
        @(posedge sys_clk);
        trg_pin[i] <= v;
        hold(4);
    endtask
endmodule // tcrt_pin_model

/* File: test/tcrt_timers_monitor.sv */
// Port-level checker for the three-timer block, with its bind
`timescale 1ns/1ps
module tcrt_timers_monitor (
    input wire       sys_clk,
    input wire       rstn,
    input wire [4:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       ext_osc_clk,
    input wire       shared_count_pin,
    input wire       shared_trigger_pin,
    input wire       count_pin_four,
    input wire       trigger_pin_four,
    input wire       toggle_pin_two,
    input wire       toggle_pin_two_oe_n,
    input wire       toggle_pin_four,
    input wire       toggle_pin_four_oe_n,
    input wire [2:0] timer_irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    a_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    a_unmapped_bank: assert property (
        $past(reg_rd) && $past(reg_addr[4:3]) == 2'h3 |-> reg_rdata == 8'h00)
        else $error("unmapped bank read not zero");
    a_spare_offset: assert property (
        $past(reg_rd) && $past(reg_addr[2:1]) == 2'h3 |-> reg_rdata == 8'h00)
        else $error("spare offset read not zero");
    a_ctl_spare_bits: assert property (
        $past(reg_rd) && $past(reg_addr[2:0]) == 3'h0 |-> reg_rdata[5:4] == 2'h0)
        else $error("control spare bits not zero");
    a_cfg_spare_bits: assert property (
        $past(reg_rd) && $past(reg_addr[2:0]) == 3'h1 |-> reg_rdata[7:5] == 3'h0)
        else $error("config spare bits not zero");
    a_oe_two_follow: assert property (
        reg_wr && reg_addr == 5'h01 |=> toggle_pin_two_oe_n == !$past(reg_wdata[1]))
        else $error("timer two enable pin wrong");
    a_oe_four_follow: assert property (
        reg_wr && reg_addr == 5'h11 |=> toggle_pin_four_oe_n == !$past(reg_wdata[1]))
        else $error("timer four enable pin wrong");
    a_toggle_force: assert property (
        reg_wr && reg_addr == 5'h01 |=> toggle_pin_two == $past(reg_wdata[2]))
        else $error("toggle level not forced");
    a_flag_keep: assert property (
        |($past(timer_irq) & ~timer_irq) |-> $past(reg_wr))
        else $error("request dropped without a write");
    cover property ($past(reg_rd) && $past(reg_addr[4:3]) == 2'h3);
    cover property ($rose(timer_irq[0]));
    cover property ($rose(toggle_pin_four));
endmodule // tcrt_timers_monitor

bind tcrt_timers tcrt_timers_monitor mon (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_osc_clk(ext_osc_clk),
    .shared_count_pin(shared_count_pin), .shared_trigger_pin(shared_trigger_pin),
    .count_pin_four(count_pin_four), .trigger_pin_four(trigger_pin_four),
    .toggle_pin_two(toggle_pin_two), .toggle_pin_two_oe_n(toggle_pin_two_oe_n),
    .toggle_pin_four(toggle_pin_four), .toggle_pin_four_oe_n(toggle_pin_four_oe_n),
    .timer_irq(timer_irq));

/* File: test/tcrt_timers_bench.sv */
// Directed bench for the three-timer block
`timescale 1ns/1ps
module tcrt_timers_bench;
    logic       sys_clk;
    logic       rstn;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       ext_osc_clk;
    logic [1:0] cnt_pin;
    logic [1:0] trg_pin;
    logic       tog2;
    logic       tog2_oe_n;
    logic       tog4;
    logic       tog4_oe_n;
    logic [2:0] timer_irq;
    int         n_errors = 0;
    int         n_compared = 0;

    tcrt_timers dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_osc_clk(ext_osc_clk), .shared_count_pin(cnt_pin[0]),
        .shared_trigger_pin(trg_pin[0]), .count_pin_four(cnt_pin[1]),
        .trigger_pin_four(trg_pin[1]), .toggle_pin_two(tog2), .toggle_pin_two_oe_n(tog2_oe_n),
        .toggle_pin_four(tog4), .toggle_pin_four_oe_n(tog4_oe_n), .timer_irq(timer_irq));
    tcrt_pin_model pm (.sys_clk(sys_clk), .ext_osc_clk(ext_osc_clk), .cnt_pin(cnt_pin),
        .trg_pin(trg_pin));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rchk(input logic [4:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk($sformatf("register %h", a), e, reg_rdata);
    endtask
    // Timer two counts one clock source over a window of n + 2 run edges
    task automatic src_run(input logic [7:0] cfg, input int n, input logic [7:0] e);
        wr(5'h04, 8'h00);
        wr(5'h05, 8'h00);
        wr(5'h01, cfg);
        wr(5'h00, 8'h05);
        repeat (n) @(posedge sys_clk);
        wr(5'h00, 8'h00);
        rchk(5'h04, e);
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        test_done();
    end

    initial begin
        rstn = 1'b0; reg_addr = 5'h00; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        rchk(5'h00, 8'h00);
        rchk(5'h18, 8'h00);
        $display("test reset done");
        // Timer two, capture mode, undivided clock, counts up through overflow
        wr(5'h05, 8'hFF);
        wr(5'h04, 8'hF0);
        wr(5'h01, 8'h08);
        wr(5'h00, 8'h05);
        repeat (40) @(posedge sys_clk);
        rchk(5'h00, 8'h85);
        chk("irq two", 8'h01, {7'h00, timer_irq[0]});
        wr(5'h00, 8'h00);
        rchk(5'h00, 8'h00);
        rchk(5'h04, 8'h1C);
        $display("test overflow done");
        // Timer three counts shared pin edges, then a trigger edge captures
        wr(5'h08, 8'h0F);
        repeat (3) pm.cnt_fall(0);
        pm.trg_set(0, 1'b0);
        pm.trg_set(0, 1'b1);
        rchk(5'h0A, 8'h03);
        rchk(5'h0B, 8'h00);
        rchk(5'h08, 8'h4F);
        chk("irq three", 8'h01, {7'h00, timer_irq[1]});
        rchk(5'h00, 8'h00);
        $display("test capture done");
        // Divided system clock and external oscillator sources on timer two
        src_run(8'h18, 22, 8'h0C);
        src_run(8'h00, 22, 8'h02);
        src_run(8'h10, 192, 8'h05);
        $display("test clock source done");
        // Timer four reload mode up, toggling its pin
        wr(5'h12, 8'hFE);
        wr(5'h13, 8'hFF);
        wr(5'h14, 8'hFE);
        wr(5'h15, 8'hFF);
        wr(5'h11, 8'h02);
        wr(5'h10, 8'h06);
        repeat (2) pm.cnt_fall(1);
        rchk(5'h14, 8'hFE);
        rchk(5'h10, 8'hC6);
        chk("toggle four", 8'h01, {7'h00, tog4});
        chk("enable four", 8'h00, {7'h00, tog4_oe_n});
        chk("irq four", 8'h01, {7'h00, timer_irq[2]});
        $display("test reload up done");
        // Timer four counting down, wrapping to all ones when the count equals the reload value
        wr(5'h10, 8'h00);
        wr(5'h12, 8'h05);
        wr(5'h13, 8'h00);
        wr(5'h14, 8'h05);
        wr(5'h15, 8'h00);
        wr(5'h11, 8'h01);
        wr(5'h10, 8'h0E);
        pm.trg_set(1, 1'b0);
        rchk(5'h10, 8'h0E);
        pm.cnt_fall(1);
        rchk(5'h14, 8'hFF);
        rchk(5'h15, 8'hFF);
        rchk(5'h10, 8'hCE);
        chk("toggle four", 8'h01, {7'h00, tog4});
        wr(5'h10, 8'h4E);
        @(negedge sys_clk);
        chk("irq four", 8'h00, {7'h00, timer_irq[2]});
        wr(5'h10, 8'h0E);
        wr(5'h11, 8'h00);
        pm.trg_set(1, 1'b1);
        pm.trg_set(1, 1'b0);
        rchk(5'h14, 8'h05);
        rchk(5'h10, 8'h4E);
        $display("test reload down done");
        // Toggle level forced through the config register of timer two
        wr(5'h01, 8'h04);
        @(negedge sys_clk);
        chk("toggle two", 8'h01, {7'h00, tog2});
        chk("enable two", 8'h01, {7'h00, tog2_oe_n});
        wr(5'h01, 8'h06);
        @(negedge sys_clk);
        chk("enable two", 8'h00, {7'h00, tog2_oe_n});
        rchk(5'h01, 8'h06);
        $display("test toggle done");
        test_done();
    end
endmodule // tcrt_timers_bench
